//--- design/xmii_pkg.sv
// Shared constants and types for the extension-port media-independent link.
// Assumes both link ends and the bench import this package.
package xmii_pkg;

	// ----------------------------------------
	// Port modes and link speeds
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_RGMII   = 2'b00,
		MODE_MII_MAC = 2'b01,
		MODE_MII_PHY = 2'b10
	} mode_t;

	typedef enum logic [1:0] {
		SPD_10   = 2'b00,
		SPD_100  = 2'b01,
		SPD_1000 = 2'b10
	} speed_t;

	// ----------------------------------------
	// Widths and depths
	// ----------------------------------------
	localparam int NIBBLE_W   = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int DIV_W      = 6;

	// ----------------------------------------
	// Link clock frequencies, derived from a 250 MHz reference clock
	// ----------------------------------------
	localparam int REF_CLK_KHZ = 250000;
	localparam int F_1000_KHZ  = 125000;
	localparam int F_100_KHZ   = 25000;
	localparam int F_10_KHZ    = 2500;
	localparam logic [DIV_W-1:0] HALF_1000 = DIV_W'(REF_CLK_KHZ / (2 * F_1000_KHZ));
	localparam logic [DIV_W-1:0] HALF_100  = DIV_W'(REF_CLK_KHZ / (2 * F_100_KHZ));
	localparam logic [DIV_W-1:0] HALF_10   = DIV_W'(REF_CLK_KHZ / (2 * F_10_KHZ));

	// Reference cycles per link clock half period; MII never runs gigabit
	function automatic logic [DIV_W-1:0] half_period(mode_t m, speed_t s);
		if (s == SPD_10) begin
			return HALF_10;
		end else if (s == SPD_100 || m != MODE_RGMII) begin
			return HALF_100;
		end else begin
			return HALF_1000;
		end
	endfunction

endpackage

//--- design/xmii_if.sv
// Pin-level carrier between the switch extension port and its link partner.
// Assumes each end drives only the signals of its own modport.
`timescale 1ns/100ps

interface xmii_if;
	import xmii_pkg::*;

	// Clock pins are two-way; data and control pins have one fixed driver
	logic                a_clk_dev;
	logic                a_clk_dev_oe;
	logic                a_clk_far;
	logic                a_clk_far_oe;
	logic                b_clk_dev;
	logic                b_clk_dev_oe;
	logic                b_clk_far;
	logic                b_clk_far_oe;
	logic                a_ctl;
	logic [NIBBLE_W-1:0] a_data;
	logic                b_ctl;
	logic [NIBBLE_W-1:0] b_data;
	logic                a_clk;
	logic                b_clk;

	// Undriven clock wire reads low
	assign a_clk = a_clk_dev_oe ? a_clk_dev : (a_clk_far_oe ? a_clk_far : 1'b0);
	assign b_clk = b_clk_dev_oe ? b_clk_dev : (b_clk_far_oe ? b_clk_far : 1'b0);

	modport dev_mp (
		output a_clk_dev, a_clk_dev_oe, b_clk_dev, b_clk_dev_oe, a_ctl, a_data,
		input  a_clk, b_clk, b_ctl, b_data
	);

	modport far_mp (
		output a_clk_far, a_clk_far_oe, b_clk_far, b_clk_far_oe, b_ctl, b_data,
		input  a_clk, b_clk, a_ctl, a_data
	);
endinterface

//--- design/xmii_dev_end.sv
// Switch extension port end of the link, plus the dual-clock FIFO both ends use.
// Assumes a 200 MHz core clock, a 250 MHz reference clock and a mode fixed before traffic.
`timescale 1ns/100ps

// ----------------------------------------
// Dual-clock FIFO with gray-coded pointers
// ----------------------------------------
module xmii_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 4
) (
	input  wire logic             wr_clk_i,
	input  wire logic             rd_clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             wr_valid_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  wr_ready_o,
	output logic                  rd_valid_o,
	output logic [WIDTH-1:0]      rd_data_o,
	input  wire logic             rd_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wbin_q;
	logic [AW:0]      wgray_q;
	logic [AW:0]      rbin_q;
	logic [AW:0]      rgray_q;
	logic [AW:0]      rgray_s1_q;
	logic [AW:0]      rgray_s2_q;
	logic [AW:0]      wgray_s1_q;
	logic [AW:0]      wgray_s2_q;
	logic [AW:0]      wbin_d;
	logic [AW:0]      rbin_d;
	logic             push;
	logic             pop;

	assign wbin_d     = wbin_q + (AW+1)'(1);
	assign rbin_d     = rbin_q + (AW+1)'(1);
	// Full when the write pointer is one lap ahead of the synced read pointer
	assign wr_ready_o = (wgray_q != {~rgray_s2_q[AW:AW-1], rgray_s2_q[AW-2:0]});
	assign rd_valid_o = (rgray_q != wgray_s2_q);
	assign rd_data_o  = mem_q[rbin_q[AW-1:0]];
	assign push       = wr_valid_i && wr_ready_o;
	assign pop        = rd_valid_o && rd_ready_i;

	always_ff @(posedge wr_clk_i) begin
		if (push) begin
			mem_q[wbin_q[AW-1:0]] <= wr_data_i;
		end
	end

	always_ff @(posedge wr_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wbin_q     <= '0;
			wgray_q    <= '0;
			rgray_s1_q <= '0;
			rgray_s2_q <= '0;
		end else begin
			rgray_s1_q <= rgray_q;
			rgray_s2_q <= rgray_s1_q;
			if (push) begin
				wbin_q  <= wbin_d;
				wgray_q <= wbin_d ^ (wbin_d >> 1);
			end
		end
	end

	always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rbin_q     <= '0;
			rgray_q    <= '0;
			wgray_s1_q <= '0;
			wgray_s2_q <= '0;
		end else begin
			wgray_s1_q <= wgray_q;
			wgray_s2_q <= wgray_s1_q;
			if (pop) begin
				rbin_q  <= rbin_d;
				rgray_q <= rbin_d ^ (rbin_d >> 1);
			end
		end
	end
endmodule

// Functional notes
// - RGMII gigabit transmit clock runs at 125 MHz
// - RGMII transmit clock 2.5/25 MHz at 10/100
// - RGMII transmit clock pin is always an output
// - RGMII transmit control driven out by the device
// - RGMII transmit data is a 4-bit output
// - PHY supplies continuous RGMII receive clock
// - PHY drives RGMII receive control and data
// - MII MAC mode: PHY supplies transmit clock
// - MII MAC transmit enable marks valid data exactly
// - MII MAC transmit data follows PHY clock
// - MII MAC mode: PHY drives clock, valid, data
// - MII PHY mode: device drives receive clock
// - MII clocks 25 MHz or 2.5 MHz
// - MII PHY receive valid marks presented data
// - MII PHY receive data follows own clock
// - MII PHY mode: device drives transmit clock
// - MII PHY: MAC asserts enable on device clock
// - MII PHY mode: MAC data on device clock
module xmii_dev_end
	import xmii_pkg::*;
(
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_b_i,
	input  wire logic                    ref_clk_i,
	input  wire xmii_pkg::mode_t         mode_i,
	input  wire xmii_pkg::speed_t        speed_i,
	input  wire logic                    tx_enable_i,
	input  wire logic                    tx_valid_i,
	input  wire logic [xmii_pkg::NIBBLE_W-1:0] tx_data_i,
	output logic                         tx_ready_o,
	output logic                         rx_valid_o,
	output logic [xmii_pkg::NIBBLE_W-1:0] rx_data_o,
	input  wire logic                    rx_ready_i,
	output logic                         rx_overrun_o,
	xmii_if.dev_mp                       link
);
	import xmii_pkg::*;

	// ----------------------------------------
	// Reference domain: mode capture and link clock divider
	// ----------------------------------------
	mode_t            mode_s1_q;
	mode_t            mode_q;
	speed_t           speed_s1_q;
	speed_t           speed_q;
	logic [DIV_W-1:0] div_cnt_q;
	logic             gen_clk_q;
	logic             a_oe_q;
	logic             b_oe_q;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_s1_q  <= MODE_RGMII;
			mode_q     <= MODE_RGMII;
			speed_s1_q <= SPD_10;
			speed_q    <= SPD_10;
		end else begin
			mode_s1_q  <= mode_i;
			mode_q     <= mode_s1_q;
			speed_s1_q <= speed_i;
			speed_q    <= speed_s1_q;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_cnt_q <= '0;
			gen_clk_q <= 1'b0;
		end else if (div_cnt_q >= half_period(mode_q, speed_q) - DIV_W'(1)) begin
			div_cnt_q <= '0;
			gen_clk_q <= ~gen_clk_q;
		end else begin
			div_cnt_q <= div_cnt_q + DIV_W'(1);
		end
	end

	// Pin directions are registered so a mode change never glitches the pads
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_oe_q <= 1'b0;
			b_oe_q <= 1'b0;
		end else begin
			a_oe_q <= (mode_q != MODE_MII_MAC);
			b_oe_q <= (mode_q == MODE_MII_PHY);
		end
	end

	assign link.a_clk_dev    = gen_clk_q;
	assign link.a_clk_dev_oe = a_oe_q;
	assign link.b_clk_dev    = gen_clk_q;
	assign link.b_clk_dev_oe = b_oe_q;

	// ----------------------------------------
	// Outgoing path: core side into FIFO, drained on the outgoing pin clock
	// ----------------------------------------
	logic                tx_en_s1_q;
	logic                tx_en_q;
	logic                out_valid;
	logic [NIBBLE_W-1:0] out_data;
	logic                out_ctl_q;
	logic [NIBBLE_W-1:0] out_data_q;

	xmii_fifo #(
		.WIDTH (NIBBLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.wr_clk_i   (core_clk_i),
		.rd_clk_i   (link.a_clk),
		.rst_b_i    (rst_b_i),
		.wr_valid_i (tx_valid_i),
		.wr_data_i  (tx_data_i),
		.wr_ready_o (tx_ready_o),
		.rd_valid_o (out_valid),
		.rd_data_o  (out_data),
		.rd_ready_i (tx_en_q)
	);

	always_ff @(posedge link.a_clk or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_en_s1_q <= 1'b0;
			tx_en_q    <= 1'b0;
		end else begin
			tx_en_s1_q <= tx_enable_i;
			tx_en_q    <= tx_en_s1_q;
		end
	end

	// Control is high exactly for the cycles that carry a popped nibble
	always_ff @(posedge link.a_clk or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_ctl_q  <= 1'b0;
			out_data_q <= '0;
		end else begin
			out_ctl_q  <= out_valid && tx_en_q;
			out_data_q <= (out_valid && tx_en_q) ? out_data : '0;
		end
	end

	assign link.a_ctl  = out_ctl_q;
	assign link.a_data = out_data_q;

	// ----------------------------------------
	// Incoming path: sampled on the incoming pin clock into FIFO
	// ----------------------------------------
	logic in_ready;
	logic overrun_q;
	logic ovr_s1_q;
	logic ovr_q;

	xmii_fifo #(
		.WIDTH (NIBBLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.wr_clk_i   (link.b_clk),
		.rd_clk_i   (core_clk_i),
		.rst_b_i    (rst_b_i),
		.wr_valid_i (link.b_ctl),
		.wr_data_i  (link.b_data),
		.wr_ready_o (in_ready),
		.rd_valid_o (rx_valid_o),
		.rd_data_o  (rx_data_o),
		.rd_ready_i (rx_ready_i)
	);

	// The partner cannot be stalled, so a full FIFO drops the nibble and is flagged
	always_ff @(posedge link.b_clk or negedge rst_b_i) begin
		if (!rst_b_i) begin
			overrun_q <= 1'b0;
		end else if (link.b_ctl && !in_ready) begin
			overrun_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovr_s1_q <= 1'b0;
			ovr_q    <= 1'b0;
		end else begin
			ovr_s1_q <= overrun_q;
			ovr_q    <= ovr_s1_q;
		end
	end

	assign rx_overrun_o = ovr_q;
endmodule

//--- design/xmii_far_end.sv
// Link partner end: external PHY (RGMII, MII MAC mode) or external MAC (MII PHY mode).
// Assumes a 250 MHz own clock and the FIFO module from the switch end file.
`timescale 1ns/100ps

module xmii_far_end
	import xmii_pkg::*;
(
	input  wire logic                    far_clk_i,
	input  wire logic                    rst_b_i,
	input  wire xmii_pkg::mode_t         mode_i,
	input  wire xmii_pkg::speed_t        speed_i,
	input  wire logic                    send_valid_i,
	input  wire logic [xmii_pkg::NIBBLE_W-1:0] send_data_i,
	output logic                         send_ready_o,
	output logic                         recv_valid_o,
	output logic [xmii_pkg::NIBBLE_W-1:0] recv_data_o,
	input  wire logic                    recv_ready_i,
	output logic                         recv_overrun_o,
	xmii_if.far_mp                       link
);
	import xmii_pkg::*;

	// ----------------------------------------
	// Own clock domain: mode capture and link clock divider
	// ----------------------------------------
	mode_t            mode_s1_q;
	mode_t            mode_q;
	speed_t           speed_s1_q;
	speed_t           speed_q;
	logic [DIV_W-1:0] div_cnt_q;
	logic             gen_clk_q;
	logic             a_oe_q;
	logic             b_oe_q;

	always_ff @(posedge far_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_s1_q  <= MODE_RGMII;
			mode_q     <= MODE_RGMII;
			speed_s1_q <= SPD_10;
			speed_q    <= SPD_10;
		end else begin
			mode_s1_q  <= mode_i;
			mode_q     <= mode_s1_q;
			speed_s1_q <= speed_i;
			speed_q    <= speed_s1_q;
		end
	end

	// Runs free so the incoming clock towards the switch is continuous
	always_ff @(posedge far_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_cnt_q <= '0;
			gen_clk_q <= 1'b0;
		end else if (div_cnt_q >= half_period(mode_q, speed_q) - DIV_W'(1)) begin
			div_cnt_q <= '0;
			gen_clk_q <= ~gen_clk_q;
		end else begin
			div_cnt_q <= div_cnt_q + DIV_W'(1);
		end
	end

	always_ff @(posedge far_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_oe_q <= 1'b0;
			b_oe_q <= 1'b0;
		end else begin
			a_oe_q <= (mode_q == MODE_MII_MAC);
			b_oe_q <= (mode_q != MODE_MII_PHY);
		end
	end

	assign link.a_clk_far    = gen_clk_q;
	assign link.a_clk_far_oe = a_oe_q;
	assign link.b_clk_far    = gen_clk_q;
	assign link.b_clk_far_oe = b_oe_q;

	// ----------------------------------------
	// Partner to switch: driven on the incoming-side pin clock
	// ----------------------------------------
	logic                snd_valid;
	logic [NIBBLE_W-1:0] snd_data;
	logic                snd_ctl_q;
	logic [NIBBLE_W-1:0] snd_data_q;

	xmii_fifo #(
		.WIDTH (NIBBLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_send_fifo (
		.wr_clk_i   (far_clk_i),
		.rd_clk_i   (link.b_clk),
		.rst_b_i    (rst_b_i),
		.wr_valid_i (send_valid_i),
		.wr_data_i  (send_data_i),
		.wr_ready_o (send_ready_o),
		.rd_valid_o (snd_valid),
		.rd_data_o  (snd_data),
		.rd_ready_i (1'b1)
	);

	always_ff @(posedge link.b_clk or negedge rst_b_i) begin
		if (!rst_b_i) begin
			snd_ctl_q  <= 1'b0;
			snd_data_q <= '0;
		end else begin
			snd_ctl_q  <= snd_valid;
			snd_data_q <= snd_valid ? snd_data : '0;
		end
	end

	assign link.b_ctl  = snd_ctl_q;
	assign link.b_data = snd_data_q;

	// ----------------------------------------
	// Switch to partner: sampled on the outgoing-side pin clock
	// ----------------------------------------
	logic rcv_ready;
	logic overrun_q;
	logic ovr_s1_q;
	logic ovr_q;

	xmii_fifo #(
		.WIDTH (NIBBLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_recv_fifo (
		.wr_clk_i   (link.a_clk),
		.rd_clk_i   (far_clk_i),
		.rst_b_i    (rst_b_i),
		.wr_valid_i (link.a_ctl),
		.wr_data_i  (link.a_data),
		.wr_ready_o (rcv_ready),
		.rd_valid_o (recv_valid_o),
		.rd_data_o  (recv_data_o),
		.rd_ready_i (recv_ready_i)
	);

	always_ff @(posedge link.a_clk or negedge rst_b_i) begin
		if (!rst_b_i) begin
			overrun_q <= 1'b0;
		end else if (link.a_ctl && !rcv_ready) begin
			overrun_q <= 1'b1;
		end
	end

	always_ff @(posedge far_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovr_s1_q <= 1'b0;
			ovr_q    <= 1'b0;
		end else begin
			ovr_s1_q <= overrun_q;
			ovr_q    <= ovr_s1_q;
		end
	end

	assign recv_overrun_o = ovr_q;
endmodule

//--- tb/xmii_chk.sv
// Concurrent checks on the pins of the extension-port link.
// Assumes both ends divide their link clocks from one shared reference clock.
`timescale 1ns/100ps

module xmii_chk
	import xmii_pkg::*;
(
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_b_i,
	input  wire xmii_pkg::mode_t               mode_i,
	input  wire xmii_pkg::speed_t              speed_i,
	input  wire logic                          a_clk,
	input  wire logic                          b_clk,
	input  wire logic                          a_clk_dev_oe,
	input  wire logic                          a_clk_far_oe,
	input  wire logic                          b_clk_dev_oe,
	input  wire logic                          b_clk_far_oe,
	input  wire logic                          a_ctl,
	input  wire logic [xmii_pkg::NIBBLE_W-1:0] a_data,
	input  wire logic                          b_ctl,
	input  wire logic [xmii_pkg::NIBBLE_W-1:0] b_data
);
	// ----------------------------------------
	// Clock high-phase counter
	// ----------------------------------------
	logic [6:0] a_hi_q;
	logic       a_seen_q;
	logic [6:0] exp_half;

	assign exp_half = (speed_i == SPD_10) ? 7'h32 :
		((speed_i == SPD_100 || mode_i != MODE_RGMII) ? 7'h05 : 7'h01);

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_hi_q <= 7'h00;
		end else begin
			a_hi_q <= a_clk ? a_hi_q + 7'h01 : 7'h00;
		end
	end

	// The first high phase may start mid-divide, so it is not judged
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_seen_q <= 1'b0;
		end else begin
			a_seen_q <= a_seen_q | (!a_clk && a_hi_q != 7'h00);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_rgmii_dirs: assert property (mode_i == MODE_RGMII && $past(rst_b_i, 6) |->
		a_clk_dev_oe && !a_clk_far_oe && b_clk_far_oe && !b_clk_dev_oe)
		else $error("pin directions wrong in RGMII mode");
	chk_mac_dirs: assert property (mode_i == MODE_MII_MAC && $past(rst_b_i, 6) |->
		!a_clk_dev_oe && a_clk_far_oe && b_clk_far_oe && !b_clk_dev_oe)
		else $error("pin directions wrong in MII MAC mode");
	chk_phy_dirs: assert property (mode_i == MODE_MII_PHY && $past(rst_b_i, 6) |->
		a_clk_dev_oe && !a_clk_far_oe && !b_clk_far_oe && b_clk_dev_oe)
		else $error("pin directions wrong in MII PHY mode");
	chk_a_idle_zero: assert property (!a_ctl |-> a_data == 4'h0)
		else $error("group A data without control");
	chk_b_idle_zero: assert property (!b_ctl |-> b_data == 4'h0)
		else $error("group B data without control");
	chk_a_edge_sync: assert property ($changed({a_ctl, a_data}) |-> $rose(a_clk))
		else $error("group A changed off its clock edge");
	chk_b_edge_sync: assert property ($changed({b_ctl, b_data}) |-> $rose(b_clk))
		else $error("group B changed off its clock edge");
	chk_a_clk_rate: assert property (a_seen_q && $fell(a_clk) |-> a_hi_q == exp_half)
		else $error("group A clock half period wrong");

	cover property (a_ctl && mode_i == MODE_MII_MAC);
	cover property (b_ctl && mode_i == MODE_MII_PHY);
	cover property ($fell(a_clk) && a_hi_q == 7'h01);
endmodule

//--- tb/xmii_extension_port_pins_tb.sv
// Self-checking bench joining the switch end and the partner end over one link.
// Assumes one 250 MHz reference feeds both ends and mode changes only under reset.
`timescale 1ns/100ps

module xmii_extension_port_pins_tb;
	import xmii_pkg::*;

	logic                core_clk_i;
	logic                ref_clk_i;
	logic                rst_b_i;
	mode_t               mode_i;
	speed_t              speed_i;
	logic                tx_enable_i;
	logic                tx_valid_i;
	logic [NIBBLE_W-1:0] tx_data_i;
	logic                tx_ready_o;
	logic                rx_valid_o;
	logic [NIBBLE_W-1:0] rx_data_o;
	logic                rx_ready_i;
	logic                rx_overrun_o;
	logic                send_valid_i;
	logic [NIBBLE_W-1:0] send_data_i;
	logic                send_ready_o;
	logic                recv_valid_o;
	logic [NIBBLE_W-1:0] recv_data_o;
	logic                recv_ready_i;
	logic                recv_overrun_o;
	logic [NIBBLE_W-1:0] a_q[$];
	logic [NIBBLE_W-1:0] b_q[$];
	logic [NIBBLE_W-1:0] f_q[$];
	logic [NIBBLE_W-1:0] r_q[$];
	int                  err_total;
	int                  cmp_count;
	mode_t               mt[8] = '{MODE_RGMII, MODE_RGMII, MODE_RGMII, MODE_MII_MAC,
		MODE_MII_MAC, MODE_MII_MAC, MODE_MII_PHY, MODE_MII_PHY};
	speed_t              st[8] = '{SPD_10, SPD_100, SPD_1000, SPD_10, SPD_100, SPD_1000, SPD_10, SPD_100};
	int                  per_ns[8] = '{400, 40, 8, 400, 40, 40, 400, 40};

	xmii_if xmii_if_inst ();

	xmii_dev_end xmii_dev_end_inst (
		.core_clk_i,
		.rst_b_i,
		.ref_clk_i,
		.mode_i,
		.speed_i,
		.tx_enable_i,
		.tx_valid_i,
		.tx_data_i,
		.tx_ready_o,
		.rx_valid_o,
		.rx_data_o,
		.rx_ready_i,
		.rx_overrun_o,
		.link         (xmii_if_inst)
	);

	xmii_far_end xmii_far_end_inst (
		.far_clk_i      (ref_clk_i),
		.rst_b_i,
		.mode_i,
		.speed_i,
		.send_valid_i,
		.send_data_i,
		.send_ready_o,
		.recv_valid_o,
		.recv_data_o,
		.recv_ready_i,
		.recv_overrun_o,
		.link           (xmii_if_inst)
	);

	xmii_chk xmii_chk_inst (
		.ref_clk_i,
		.rst_b_i,
		.mode_i,
		.speed_i,
		.a_clk        (xmii_if_inst.a_clk),
		.b_clk        (xmii_if_inst.b_clk),
		.a_clk_dev_oe (xmii_if_inst.a_clk_dev_oe),
		.a_clk_far_oe (xmii_if_inst.a_clk_far_oe),
		.b_clk_dev_oe (xmii_if_inst.b_clk_dev_oe),
		.b_clk_far_oe (xmii_if_inst.b_clk_far_oe),
		.a_ctl        (xmii_if_inst.a_ctl),
		.a_data       (xmii_if_inst.a_data),
		.b_ctl        (xmii_if_inst.b_ctl),
		.b_data       (xmii_if_inst.b_data)
	);

	// ----------------------------------------
	// Clocks, watchdog and monitors
	// ----------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end

	// Wire monitors read the nibble launched one link edge earlier
	always @(posedge xmii_if_inst.a_clk)
		if (xmii_if_inst.a_ctl === 1'b1) a_q.push_back(xmii_if_inst.a_data);
	always @(posedge xmii_if_inst.b_clk)
		if (xmii_if_inst.b_ctl === 1'b1) b_q.push_back(xmii_if_inst.b_data);
	always @(posedge ref_clk_i)
		if (recv_valid_o === 1'b1 && recv_ready_i === 1'b1) f_q.push_back(recv_data_o);
	always @(posedge core_clk_i)
		if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) r_q.push_back(rx_data_o);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Mode is static, so every new mode goes through a full reset
	task automatic cfg(input mode_t m, input speed_t s);
		@(negedge core_clk_i);
		rst_b_i = 1'b0;
		mode_i = m;
		speed_i = s;
		a_q.delete();
		b_q.delete();
		f_q.delete();
		r_q.delete();
		repeat (6) @(negedge core_clk_i);
		rst_b_i = 1'b1;
		repeat (20) @(negedge core_clk_i);
	endtask

	task automatic dev_send(input int n, input logic [3:0] b);
		int i;
		int k;
		for (i = 0; i < n; i++) begin
			tx_valid_i = 1'b1;
			tx_data_i = 4'(b + i);
			k = 0;
			while (tx_ready_o !== 1'b1 && k < 5000) begin
				@(negedge core_clk_i);
				k++;
			end
			@(negedge core_clk_i);
		end
		tx_valid_i = 1'b0;
	endtask

	task automatic far_send(input int n, input logic [3:0] b);
		int i;
		int k;
		@(negedge ref_clk_i);
		for (i = 0; i < n; i++) begin
			send_valid_i = 1'b1;
			send_data_i = 4'(b + i);
			k = 0;
			while (send_ready_o !== 1'b1 && k < 5000) begin
				@(negedge ref_clk_i);
				k++;
			end
			@(negedge ref_clk_i);
		end
		send_valid_i = 1'b0;
		@(negedge core_clk_i);
	endtask

	task automatic wait_q(input int na, input int nf, input int nr);
		int k;
		k = 0;
		while ((a_q.size() < na || f_q.size() < nf || r_q.size() < nr) && k < 20000) begin
			@(negedge core_clk_i);
			k++;
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic link_traffic(input int c);
		realtime t0;
		int i;
		cfg(mt[c], st[c]);
		chk("a_dev_oe", 16'(mt[c] != MODE_MII_MAC), 16'(xmii_if_inst.a_clk_dev_oe));
		chk("a_far_oe", 16'(mt[c] == MODE_MII_MAC), 16'(xmii_if_inst.a_clk_far_oe));
		chk("b_dev_oe", 16'(mt[c] == MODE_MII_PHY), 16'(xmii_if_inst.b_clk_dev_oe));
		chk("b_far_oe", 16'(mt[c] != MODE_MII_PHY), 16'(xmii_if_inst.b_clk_far_oe));
		@(posedge xmii_if_inst.a_clk);
		t0 = $realtime;
		@(posedge xmii_if_inst.a_clk);
		chk("a_period", 16'(per_ns[c]), 16'(int'($realtime - t0)));
		@(posedge xmii_if_inst.b_clk);
		t0 = $realtime;
		@(posedge xmii_if_inst.b_clk);
		chk("b_period", 16'(per_ns[c]), 16'(int'($realtime - t0)));
		@(negedge core_clk_i);
		dev_send(6, 4'(c + 2));
		far_send(6, 4'(c * 3));
		wait_q(0, 6, 6);
		for (i = 0; i < 6; i++) begin
			chk("a_wire", 16'((c + 2 + i) % 16), 16'(a_q[i]));
			chk("far_rx", 16'((c + 2 + i) % 16), 16'(f_q[i]));
			chk("b_wire", 16'((c * 3 + i) % 16), 16'(b_q[i]));
			chk("dev_rx", 16'((c * 3 + i) % 16), 16'(r_q[i]));
		end
		chk("rx_ovr", 16'h0000, 16'(rx_overrun_o));
	endtask

	task automatic fill_hold();
		int j;
		int cnt;
		tx_enable_i = 1'b0;
		cfg(MODE_RGMII, SPD_100);
		cnt = 0;
		tx_valid_i = 1'b1;
		for (j = 0; j < 12; j++) begin
			tx_data_i = 4'(4'h5 + cnt);
			if (tx_ready_o === 1'b1) cnt++;
			@(negedge core_clk_i);
		end
		tx_valid_i = 1'b0;
		chk("accepted", 16'(FIFO_DEPTH), 16'(cnt));
		chk("ready_low", 16'h0000, 16'(tx_ready_o));
		chk("held_wire", 16'h0000, 16'(a_q.size()));
		tx_enable_i = 1'b1;
		wait_q(0, 4, 0);
		for (j = 0; j < 4; j++) chk("drained", 16'(5 + j), 16'(f_q[j]));
		repeat (20) @(negedge core_clk_i);
		chk("ready_back", 16'h0001, 16'(tx_ready_o));
	endtask

	// Far receiver stalls, so its buffer overflows on the fifth nibble
	task automatic far_stall();
		int j;
		cfg(MODE_MII_PHY, SPD_100);
		@(negedge ref_clk_i);
		recv_ready_i = 1'b0;
		@(negedge core_clk_i);
		dev_send(6, 4'ha);
		wait_q(6, 0, 0);
		repeat (20) @(negedge core_clk_i);
		chk("overrun", 16'h0001, 16'(recv_overrun_o));
		@(negedge ref_clk_i);
		recv_ready_i = 1'b1;
		@(negedge core_clk_i);
		wait_q(0, 4, 0);
		repeat (20) @(negedge core_clk_i);
		chk("kept", 16'h0004, 16'(f_q.size()));
		for (j = 0; j < 4; j++) chk("kept_data", 16'(10 + j), 16'(f_q[j]));
	endtask

	initial begin
		int c;
		err_total = 0;
		cmp_count = 0;
		rst_b_i = 1'b0;
		mode_i = MODE_RGMII;
		speed_i = SPD_10;
		tx_enable_i = 1'b1;
		tx_valid_i = 1'b0;
		tx_data_i = 4'h0;
		rx_ready_i = 1'b1;
		send_valid_i = 1'b0;
		send_data_i = 4'h0;
		recv_ready_i = 1'b1;
		for (c = 0; c < 8; c++) link_traffic(c);
		fill_hold();
		far_stall();
		wrap_up();
	end
endmodule
